// ==== design/tx_coder_pkg.sv ====
// Purpose: shared constants and types of the transmit coder with its settings
// Assumes: APB register word per index, byte address is four times the index
// Notes:   register offsets, reset values, counts and all field positions but those of the status register live here
package tx_coder_pkg;

  localparam int ADDR_W = 8;                   // apb byte address width
  localparam int DATA_W = 32;                  // apb data width

  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_CODER_RATE_AND_CODING  = 6'h14;
  localparam logic [5:0] IDX_MODULATION_PULSE_WIDTH = 6'h15;
  localparam logic [5:0] IDX_SOF_PULSE_WIDTH        = 6'h16;
  localparam logic [5:0] IDX_TYPE_B_TX_FRAMING      = 6'h17;
  localparam logic [5:0] IDX_CODER_STATUS           = 6'h18;

  // reset values
  localparam logic [7:0] RST_CODER_RATE_AND_CODING  = 8'h19;
  localparam logic [7:0] RST_MODULATION_PULSE_WIDTH = 8'h13;
  localparam logic [7:0] RST_SOF_PULSE_WIDTH        = 8'h3F;
  localparam logic [7:0] RST_TYPE_B_TX_FRAMING      = 8'h00;

  // coder_rate_and_coding fields
  localparam int FORCE_SLOT_PULSE_BIT = 7;
  localparam int ENCODER_RATE_LSB     = 3;
  localparam int TX_CODING_LSB        = 0;

  // type_b_tx_framing fields
  localparam int SUPPRESS_SOF_BIT     = 7;
  localparam int SUPPRESS_EOF_BIT     = 6;
  localparam int EOF_LENGTH_BIT       = 5;
  localparam int GUARD_LSB            = 2;
  localparam int SOF_LENGTH_LSB       = 0;

  // bit coding selections
  localparam logic [2:0] CODE_NRZ_B        = 3'h0;
  localparam logic [2:0] CODE_MILLER_A     = 3'h1;
  localparam logic [2:0] CODE_LABEL_256    = 3'h4;
  localparam logic [2:0] CODE_LABEL_NRZ    = 3'h5;
  localparam logic [2:0] CODE_VICINITY_256 = 3'h6;
  localparam logic [2:0] CODE_VICINITY_4   = 3'h7;
  localparam logic [2:0] RATE_RESERVED     = 3'h7;

  // carrier and encoder clock relation: rate = carrier / divisor
  localparam longint unsigned CARRIER_HZ = 64'd13560000;

  // type b framing lengths in etu
  localparam logic [3:0] SOF_LOW_BASE_ETU  = 4'hA;
  localparam logic [3:0] SOF_HIGH_BASE_ETU = 4'h2;
  localparam logic [3:0] EOF_BASE_ETU      = 4'hA;
  localparam logic [8:0] CHAR_SLOTS        = 9'h00A;

  // symbol slots per byte for each coding
  localparam logic [8:0] SLOTS_MILLER = 9'h010;
  localparam logic [8:0] SLOTS_ONE_OF_FOUR = 9'h010;
  localparam logic [8:0] SLOTS_ONE_OF_256  = 9'h100;
  localparam logic [8:0] SLOTS_NRZ         = 9'h008;

  // carrier divisor for each encoder rate selection
  function automatic longint unsigned rate_divisor(input logic [2:0] sel);
    case (sel)
      3'h0:    rate_divisor = 64'd16;
      3'h1:    rate_divisor = 64'd32;
      3'h2:    rate_divisor = 64'd64;
      3'h3:    rate_divisor = 64'd128;
      3'h4:    rate_divisor = 64'd128;
      3'h5:    rate_divisor = 64'd256;
      3'h6:    rate_divisor = 64'd512;
      default: rate_divisor = 64'd512;
    endcase
  endfunction

  // coder sequencer states, one-hot
  typedef enum logic [6:0] {
    ST_IDLE     = 7'b0000001,
    ST_FORCE    = 7'b0000010,
    ST_SOF_LOW  = 7'b0000100,
    ST_SOF_HIGH = 7'b0001000,
    ST_WAIT     = 7'b0010000,
    ST_SYMBOL   = 7'b0100000,
    ST_EOF      = 7'b1000000
  } coder_state_type;

endpackage

// ==== design/etu_divider.sv ====
// Purpose: one-cycle symbol tick at the selected encoder rate
// Assumes: period is at least three clock cycles
// Notes:   restart_in realigns the phase so a frame starts on a full slot
`timescale 1ns/1ps
`default_nettype none
module etu_divider #(
  parameter int CNT_W = 12
) (
  input  wire logic             clock_in,
  input  wire logic             reset_in,
  input  wire logic             restart_in,   // realign the tick phase
  input  wire logic [CNT_W-1:0] period_in,    // clock cycles per slot
  output logic                  tick_out      // one-cycle slot pulse
);
  initial begin
    if (CNT_W < 2) $error("etu_divider: CNT_W too small");
  end

  logic [CNT_W-1:0] count_reg;                // cycles elapsed in this slot
  logic             tick_reg;                 // registered slot pulse

  // a tick left from before a restart would cut the first slot short
  assign tick_out = tick_reg && !restart_in;

  // free count, wrap at period; restart lands a cycle late and the tick is
  // registered, so restart starts two counts in to keep the first slot whole
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      count_reg <= '0;
      tick_reg  <= 1'b0;
    end else if (restart_in) begin
      count_reg <= CNT_W'(2);
      tick_reg  <= 1'b0;
    end else if (count_reg >= period_in - CNT_W'(1)) begin
      count_reg <= '0;
      tick_reg  <= 1'b1;
    end else begin
      count_reg <= count_reg + CNT_W'(1);
      tick_reg  <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== design/mod_pulse_timer.sv ====
// Purpose: modulation pulse of 2 * (width + 1) clock cycles
// Assumes: start is ignored while a pulse runs
// Notes:   busy_out is the pulse itself
`timescale 1ns/1ps
`default_nettype none
module mod_pulse_timer (
  input  wire logic       clock_in,
  input  wire logic       reset_in,
  input  wire logic       start_in,     // begin a pulse
  input  wire logic [7:0] width_in,     // width register value
  output logic            busy_out      // pulse active
);
  logic [8:0] remain_reg;               // cycles left in the pulse

  // load 2*w+1 and count down to zero
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      remain_reg <= '0;
      busy_out   <= 1'b0;
    end else if (start_in && !busy_out) begin
      remain_reg <= {width_in, 1'b0} + 9'h001;
      busy_out   <= 1'b1;
    end else if (remain_reg != 9'h000) begin
      remain_reg <= remain_reg - 9'h001;
    end else begin
      busy_out   <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== design/rf_tx_coder_config.sv ====
// Purpose: transmit coder with its rate, coding, pulse width and type b framing settings
// Assumes: apb master per protocol; byte stream from same-clock logic
// Notes:   mod_out high means carrier modulated (lowered)
//
// Design decision made here: the APB register port.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - force bit set sends one slot pulse
// - force bit never cleared by hardware
// - rate codes 000-011 give 848-106 kBd
// - rate codes 100-110 for b and labels
// - coding 000 nrz b, 001 miller
// - coding 100 label 256, 101 label nrz
// - coding 110 one-of-256, 111 one-of-four
// - pulse lasts 2*(width+1) clock cycles in pulse codings
// - sof pulse uses own width register
// - framing bit 7 suppresses type b sof
// - framing bit 6 suppresses type b eof
// - eof length 11 or 10 etu
// - extra guard time 0 to 7 etu
// - sof low 10/11, high 2/3 etu
// - reset loads 19h, 13h, 3Fh
module rf_tx_coder_config #(
  parameter longint unsigned CLK_HZ = 64'd20000000,  // system clock rate
  parameter int              CNT_W  = 12             // slot period counter width
) (
  input  wire logic        clock_in,
  input  wire logic        reset_in,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        frame_start_in,   // one-cycle request to send a frame
  input  wire logic [7:0]  data_in,          // byte to send, lsb first
  input  wire logic        data_valid_in,    // byte present
  input  wire logic        data_last_in,     // byte closes the frame
  output logic             data_ready_out,   // coder takes the byte
  output logic             mod_out,          // modulator drive
  output logic             frame_busy_out    // frame or forced pulse in progress
);
  initial begin
    if (CLK_HZ * 64'd512 / tx_coder_pkg::CARRIER_HZ >= (64'd1 << CNT_W))
      $error("rf_tx_coder_config: CNT_W too small for slowest rate");
  end

  // software-visible settings
  logic [7:0] ctrl_reg;                 // coder_rate_and_coding
  logic [7:0] width_reg;                // modulation_pulse_width
  logic [7:0] sof_width_reg;            // sof_pulse_width
  logic [7:0] framing_reg;              // type_b_tx_framing

  // settings frozen for the running frame
  logic [2:0] rate_reg;
  logic [2:0] coding_reg;
  logic [7:0] fr_width_reg;
  logic [7:0] fr_sof_width_reg;
  logic [7:0] fr_framing_reg;

  tx_coder_pkg::coder_state_type state_reg;
  logic [8:0]  slot_reg;                // slot within a byte or phase
  logic [7:0]  byte_reg;                // byte being coded
  logic        last_reg;                // byte closes the frame
  logic        prev_bit_reg;            // previous miller bit
  logic        slot_pulse_done_reg;     // forced pulse already sent
  logic        tick;                    // slot tick
  logic        restart;                 // realign divider
  logic        pulse_start;             // request a modulation pulse
  logic        pulse_busy;              // pulse running
  logic        pulse_from_sof;          // pulse uses sof width
  logic [7:0]  pulse_width;
  logic [CNT_W-1:0] period;

  // apb access decode
  wire         apb_access = psel && penable && pready;
  wire  [5:0]  apb_index  = paddr[7:2];
  wire         is_type_b  = coding_reg == tx_coder_pkg::CODE_NRZ_B;
  wire         is_level   = is_type_b || coding_reg == tx_coder_pkg::CODE_LABEL_NRZ;

  // mapped index check, used for both read and write
  function automatic logic index_mapped(input logic [5:0] idx);
    index_mapped = idx >= tx_coder_pkg::IDX_CODER_RATE_AND_CODING &&
                   idx <= tx_coder_pkg::IDX_CODER_STATUS;
  endfunction

  // coding and rate codes that a frame can run with; reserved ones are refused
  function automatic logic mode_ok(input logic [7:0] ctrl);
    mode_ok = ctrl[tx_coder_pkg::ENCODER_RATE_LSB +: 3] != tx_coder_pkg::RATE_RESERVED &&
              ctrl[tx_coder_pkg::TX_CODING_LSB +: 3] != 3'h2 &&
              ctrl[tx_coder_pkg::TX_CODING_LSB +: 3] != 3'h3;
  endfunction

  // slots in one byte for the frozen coding
  function automatic logic [8:0] slots_per_byte(input logic [2:0] code);
    case (code)
      tx_coder_pkg::CODE_NRZ_B:        slots_per_byte = tx_coder_pkg::CHAR_SLOTS;
      tx_coder_pkg::CODE_MILLER_A:     slots_per_byte = tx_coder_pkg::SLOTS_MILLER;
      tx_coder_pkg::CODE_VICINITY_4:   slots_per_byte = tx_coder_pkg::SLOTS_ONE_OF_FOUR;
      tx_coder_pkg::CODE_LABEL_NRZ:    slots_per_byte = tx_coder_pkg::SLOTS_NRZ;
      default:                         slots_per_byte = tx_coder_pkg::SLOTS_ONE_OF_256;
    endcase
  endfunction

  // slot period from the frozen rate code
  // slow rates for type b and label modes
  assign period = CNT_W'(CLK_HZ * tx_coder_pkg::rate_divisor(rate_reg)
                         / tx_coder_pkg::CARRIER_HZ);

  etu_divider #(
    .CNT_W      (CNT_W)
  ) u_divider (
    .clock_in   (clock_in),
    .reset_in   (reset_in),
    .restart_in (restart),
    .period_in  (period),
    .tick_out   (tick)
  );

  // sof pulse width picked from its own register
  assign pulse_width = pulse_from_sof ? fr_sof_width_reg : fr_width_reg;

  mod_pulse_timer u_pulse (
    .clock_in (clock_in),
    .reset_in (reset_in),
    .start_in (pulse_start),
    .width_in (pulse_width),
    .busy_out (pulse_busy)
  );

  // apb handshake: no wait state, answer registered
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && !penable && !pready;
      pslverr <= psel && !penable && !pready && !index_mapped(paddr[7:2]);
      // read data captured at setup, valid in access phase
      case (paddr[7:2])
        tx_coder_pkg::IDX_CODER_RATE_AND_CODING:  prdata <= {24'h000000, ctrl_reg};
        tx_coder_pkg::IDX_MODULATION_PULSE_WIDTH: prdata <= {24'h000000, width_reg};
        tx_coder_pkg::IDX_SOF_PULSE_WIDTH:        prdata <= {24'h000000, sof_width_reg};
        tx_coder_pkg::IDX_TYPE_B_TX_FRAMING:      prdata <= {24'h000000, framing_reg};
        tx_coder_pkg::IDX_CODER_STATUS:
          prdata <= {22'h000000, slot_pulse_done_reg, frame_busy_out, 1'b0, state_reg};
        default:                                  prdata <= 32'h0000_0000;
      endcase
    end
  end

  // register writes; unmapped and status writes are dropped
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      ctrl_reg      <= tx_coder_pkg::RST_CODER_RATE_AND_CODING;
      width_reg     <= tx_coder_pkg::RST_MODULATION_PULSE_WIDTH;
      sof_width_reg <= tx_coder_pkg::RST_SOF_PULSE_WIDTH;
      framing_reg   <= tx_coder_pkg::RST_TYPE_B_TX_FRAMING;
    end else if (apb_access && pwrite) begin
      case (apb_index)
        // only software changes the force bit
        // bit 6 stored as written, software keeps it zero
        tx_coder_pkg::IDX_CODER_RATE_AND_CODING:  ctrl_reg      <= pwdata[7:0];
        // software picks 73h here for the fast label mode
        tx_coder_pkg::IDX_MODULATION_PULSE_WIDTH: width_reg     <= pwdata[7:0];
        tx_coder_pkg::IDX_SOF_PULSE_WIDTH:        sof_width_reg <= pwdata[7:0];
        tx_coder_pkg::IDX_TYPE_B_TX_FRAMING:      framing_reg   <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // forced pulse armed once per set of the bit, rearmed when it clears
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      slot_pulse_done_reg <= 1'b0;
    end else if (!ctrl_reg[tx_coder_pkg::FORCE_SLOT_PULSE_BIT]) begin
      slot_pulse_done_reg <= 1'b0;
    end else if (state_reg == tx_coder_pkg::ST_FORCE) begin
      slot_pulse_done_reg <= 1'b1;
    end
  end

  // settings frozen when a frame or forced pulse starts
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      rate_reg         <= tx_coder_pkg::RST_CODER_RATE_AND_CODING[5:3];
      coding_reg       <= tx_coder_pkg::RST_CODER_RATE_AND_CODING[2:0];
      fr_width_reg     <= tx_coder_pkg::RST_MODULATION_PULSE_WIDTH;
      fr_sof_width_reg <= tx_coder_pkg::RST_SOF_PULSE_WIDTH;
      fr_framing_reg   <= tx_coder_pkg::RST_TYPE_B_TX_FRAMING;
    end else if (state_reg == tx_coder_pkg::ST_IDLE) begin
      rate_reg         <= ctrl_reg[tx_coder_pkg::ENCODER_RATE_LSB +: 3];
      coding_reg       <= ctrl_reg[tx_coder_pkg::TX_CODING_LSB +: 3];
      fr_width_reg     <= width_reg;
      fr_sof_width_reg <= sof_width_reg;
      fr_framing_reg   <= framing_reg;
    end
  end

  // pulse requests for pulse codings, decided per slot
  always_comb begin
    pulse_start    = 1'b0;
    pulse_from_sof = 1'b0;
    case (state_reg)
      tx_coder_pkg::ST_FORCE:   pulse_start = !pulse_busy;
      tx_coder_pkg::ST_SOF_LOW: begin
        pulse_from_sof = 1'b1;
        pulse_start    = !is_level && slot_reg == 9'h000 && tick;
      end
      tx_coder_pkg::ST_SYMBOL: begin
        if (tick && !is_level) begin
          case (coding_reg)
            // miller, 1 mid-bit, 0 at start unless after a 1
            tx_coder_pkg::CODE_MILLER_A:
              pulse_start = byte_reg[slot_reg[3:1]] ? slot_reg[0]
                                                    : (!slot_reg[0] && !prev_bit_reg);
            // one-of-four, pulse in slot equal to the bit pair
            tx_coder_pkg::CODE_VICINITY_4:
              pulse_start = slot_reg[1:0] == byte_reg[{slot_reg[3:2], 1'b0} +: 2];
            // one-of-256, pulse in slot equal to the byte
            default: pulse_start = slot_reg[7:0] == byte_reg;
          endcase
        end
      end
      tx_coder_pkg::ST_EOF:     pulse_start = !is_level && slot_reg == 9'h000 && tick;
      default: ;
    endcase
  end

  // sequencer
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      state_reg      <= tx_coder_pkg::ST_IDLE;
      slot_reg       <= 9'h000;
      byte_reg       <= 8'h00;
      last_reg       <= 1'b0;
      prev_bit_reg   <= 1'b0;
      data_ready_out <= 1'b0;
      restart        <= 1'b0;
    end else begin
      restart <= 1'b0;
      case (state_reg)
        tx_coder_pkg::ST_IDLE: begin
          slot_reg     <= 9'h000;
          prev_bit_reg <= 1'b0;
          if (ctrl_reg[tx_coder_pkg::FORCE_SLOT_PULSE_BIT] && !slot_pulse_done_reg) begin
            state_reg <= tx_coder_pkg::ST_FORCE;
          end else if (frame_start_in && mode_ok(ctrl_reg)) begin
            restart <= 1'b1;
            // type b sof skipped when suppressed
            if (ctrl_reg[2:0] == tx_coder_pkg::CODE_NRZ_B &&
                framing_reg[tx_coder_pkg::SUPPRESS_SOF_BIT]) begin
              state_reg      <= tx_coder_pkg::ST_WAIT;
              data_ready_out <= 1'b1;
            end else begin
              state_reg <= tx_coder_pkg::ST_SOF_LOW;
            end
          end
        end
        tx_coder_pkg::ST_FORCE: begin
          if (pulse_busy) state_reg <= tx_coder_pkg::ST_IDLE;
        end
        tx_coder_pkg::ST_SOF_LOW: begin
          // low phase 10 or 11 etu
          if (tick) begin
            if (!is_type_b || slot_reg == 9'({tx_coder_pkg::SOF_LOW_BASE_ETU}
                + fr_framing_reg[tx_coder_pkg::SOF_LENGTH_LSB + 1]) - 9'h001) begin
              slot_reg  <= 9'h000;
              state_reg <= is_type_b ? tx_coder_pkg::ST_SOF_HIGH : tx_coder_pkg::ST_WAIT;
              data_ready_out <= !is_type_b;
            end else begin
              slot_reg <= slot_reg + 9'h001;
            end
          end
        end
        tx_coder_pkg::ST_SOF_HIGH: begin
          // high phase 2 or 3 etu
          if (tick) begin
            if (slot_reg == 9'({tx_coder_pkg::SOF_HIGH_BASE_ETU}
                + fr_framing_reg[tx_coder_pkg::SOF_LENGTH_LSB]) - 9'h001) begin
              slot_reg       <= 9'h000;
              state_reg      <= tx_coder_pkg::ST_WAIT;
              data_ready_out <= 1'b1;
            end else begin
              slot_reg <= slot_reg + 9'h001;
            end
          end
        end
        tx_coder_pkg::ST_WAIT: begin
          // line stays idle until a byte comes
          if (data_valid_in) begin
            byte_reg       <= data_in;
            last_reg       <= data_last_in;
            data_ready_out <= 1'b0;
            slot_reg       <= 9'h000;
            restart        <= 1'b1;
            state_reg      <= tx_coder_pkg::ST_SYMBOL;
          end
        end
        tx_coder_pkg::ST_SYMBOL: begin
          if (tick) begin
            if (coding_reg == tx_coder_pkg::CODE_MILLER_A && slot_reg[0])
              prev_bit_reg <= byte_reg[slot_reg[3:1]];
            // type b character plus extra guard etu
            if (slot_reg == slots_per_byte(coding_reg) - 9'h001 + (is_type_b ?
                9'(fr_framing_reg[tx_coder_pkg::GUARD_LSB +: 3]) : 9'h000)) begin
              slot_reg <= 9'h000;
              if (!last_reg) begin
                state_reg      <= tx_coder_pkg::ST_WAIT;
                data_ready_out <= 1'b1;
              // type b eof skipped when suppressed
              end else if (is_type_b && fr_framing_reg[tx_coder_pkg::SUPPRESS_EOF_BIT]) begin
                state_reg <= tx_coder_pkg::ST_IDLE;
              end else begin
                state_reg <= tx_coder_pkg::ST_EOF;
              end
            end else begin
              slot_reg <= slot_reg + 9'h001;
            end
          end
        end
        tx_coder_pkg::ST_EOF: begin
          // type b eof 10 or 11 etu, pulse codings one slot
          if (tick) begin
            if (!is_type_b || slot_reg == 9'({tx_coder_pkg::EOF_BASE_ETU}
                + fr_framing_reg[tx_coder_pkg::EOF_LENGTH_BIT]) - 9'h001) begin
              slot_reg  <= 9'h000;
              state_reg <= tx_coder_pkg::ST_IDLE;
            end else begin
              slot_reg <= slot_reg + 9'h001;
            end
          end
        end
        default: state_reg <= tx_coder_pkg::ST_IDLE;
      endcase
    end
  end

  // modulator drive; level codings follow the line, pulse codings the timer
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      mod_out        <= 1'b0;
      frame_busy_out <= 1'b0;
    end else begin
      // a pulse started on the last slot outlives the state, keep busy over it
      frame_busy_out <= state_reg != tx_coder_pkg::ST_IDLE || pulse_busy;
      // pulse codings follow the width timer; in level codings the forced pulse shows only while in ST_FORCE
      if (state_reg == tx_coder_pkg::ST_FORCE || !is_level) begin
        mod_out <= pulse_busy;
      end else begin
        case (state_reg)
          tx_coder_pkg::ST_SOF_LOW: mod_out <= 1'b1;
          tx_coder_pkg::ST_EOF:     mod_out <= 1'b1;
          // nrz, start bit low, data, stop and guard high
          tx_coder_pkg::ST_SYMBOL: begin
            if (!is_type_b) mod_out <= !byte_reg[slot_reg[2:0]];
            else if (slot_reg == 9'h000) mod_out <= 1'b1;
            else if (slot_reg <= 9'h008) mod_out <= !byte_reg[3'(slot_reg - 9'h001)];
            else mod_out <= 1'b0;
          end
          default: mod_out <= 1'b0;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ==== testbench/tx_coder_chk.sv ====
// Purpose: port checks  Assumes: apb slave  Notes: bound to the top
`timescale 1ns/1ps
`default_nettype none
module tx_coder_chk (
  input wire logic        clock_in, reset_in, psel, penable, pwrite, pready, pslverr,
  input wire logic        data_valid_in, data_ready_out, mod_out, frame_busy_out,
  input wire logic [31:0] prdata
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (reset_in);
  AST_READY_AFTER_SETUP: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  AST_READY_ONE: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  AST_ERR_READS_ZERO: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error without ready or with data");
  AST_UPPER_ZERO: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  // held in reset the field must stay unmodulated
  AST_RESET_QUIET: assert property (disable iff (1'b0) reset_in |=> !mod_out && !frame_busy_out)
    else $error("activity after reset");
  AST_PULSE_MIN: assert property ($rose(mod_out) |=> mod_out)
    else $error("pulse shorter than two cycles");
  AST_GAP_IN_BUSY: assert property ($rose(mod_out) |-> ##[0:3] frame_busy_out)
    else $error("modulation while idle");
  AST_READY_HOLDS: assert property (data_ready_out && !data_valid_in |=> data_ready_out)
    else $error("ready dropped without a byte");
endmodule
bind rf_tx_coder_config tx_coder_chk tx_coder_chk_inst (.clock_in(clock_in),
  .reset_in(reset_in), .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready),
  .pslverr(pslverr), .data_valid_in(data_valid_in), .data_ready_out(data_ready_out),
  .mod_out(mod_out), .frame_busy_out(frame_busy_out), .prdata(prdata));
`default_nettype wire

// ==== testbench/rf_card_model.sv ====
// Purpose: card side gap meter  Assumes: mod_in high is a gap  Notes: listens only
`timescale 1ns/1ps
`default_nettype none
module rf_card_model (
  input  wire logic        clock_in,
  input  wire logic        mod_in,
  output logic      [7:0]  pulse_count,
  output logic      [15:0] last_width
);
  logic [15:0] run;  // length of the gap now seen
  initial begin
    pulse_count = 8'h00;
    last_width = 16'h0000;
    run = 16'h0000;
  end
  // a gap is counted only once it ends, so its width is whole
  always @(posedge clock_in) begin
    if (mod_in === 1'b1) run <= run + 16'h0001;
    else if (run != 16'h0000) begin
      pulse_count <= pulse_count + 8'h01;
      last_width <= run;
      run <= 16'h0000;
    end
  end
endmodule
`default_nettype wire

// ==== testbench/tb_top.sv ====
// Purpose: coder bench  Assumes: 20 MHz clock  Notes: card model meters gaps
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int ETU = 188;  // cycles per slot at the type b rate
  logic clock_in = 1'b0, reset_in = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic frame_start_in = 1'b0, data_valid_in = 1'b0, data_last_in = 1'b0;
  logic [7:0] paddr = 8'h00, data_in = 8'h00, pulse_count, base;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, data_ready_out, mod_out, frame_busy_out, err;
  logic [15:0] last_width, first_w;
  logic [7:0] rst_v [4] = '{8'h19, 8'h13, 8'h3F, 8'h00};
  logic [31:0] fr [3] = '{32'h230B0B03, 32'h000A0A03, 32'hC0010101};  // frame, sof, eof, gaps
  int fail_count = 0, checks = 0, cycles = 0;
  always #25 clock_in = ~clock_in;
  rf_tx_coder_config rf_tx_coder_config_inst (.clock_in(clock_in), .reset_in(reset_in),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .frame_start_in(frame_start_in),
    .data_in(data_in), .data_valid_in(data_valid_in), .data_last_in(data_last_in),
    .data_ready_out(data_ready_out), .mod_out(mod_out), .frame_busy_out(frame_busy_out));
  rf_card_model rf_card_model_inst (.clock_in(clock_in), .mod_in(mod_out),
    .pulse_count(pulse_count), .last_width(last_width));
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check_val(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  // one transfer, held until pready; the timeout bounds the wait
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_in);
    penable <= 1'b1;
    do @(posedge clock_in); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_idle;
    repeat (3) @(posedge clock_in);
    while (frame_busy_out !== 1'b0) @(posedge clock_in);
    repeat (10) @(posedge clock_in);  // card meter logs a gap a cycle late
  endtask
  // one-byte frame; first_w keeps the first gap of the frame
  task automatic send_frame(input logic [7:0] b);
    base = pulse_count;
    @(posedge clock_in);
    frame_start_in <= 1'b1;
    data_in <= b;
    data_valid_in <= 1'b1;
    data_last_in <= 1'b1;
    @(posedge clock_in);
    frame_start_in <= 1'b0;
    do @(posedge clock_in); while (data_ready_out !== 1'b1);
    data_valid_in <= 1'b0;
    data_last_in <= 1'b0;
    while (pulse_count === base) @(posedge clock_in);
    first_w = last_width;
    wait_idle();
  endtask
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 60000) begin
      fail_count++;
      conclude();
    end
  end
  initial begin
    repeat (10) @(posedge clock_in);
    reset_in <= 1'b0;
    foreach (rst_v[i]) begin
      apb(1'b0, 8'h50 + 8'(4 * i), 32'h0);
      check_val("reset value", {24'h0, rst_v[i]}, rd);
    end
    apb(1'b1, 8'h58, 32'hFFFFFFFF);
    apb(1'b0, 8'h58, 32'h0);
    check_val("sof width", 32'hFF, rd);
    apb(1'b1, 8'h58, 32'h73);
    apb(1'b0, 8'h58, 32'h0);
    check_val("fast label sof", 32'h73, rd);
    apb(1'b1, 8'h40, 32'h5A);
    check_val("slave error", 32'h1, 32'(err));
    // forced slot pulse, then no repeat while the bit stays set
    apb(1'b1, 8'h54, 32'h05);
    apb(1'b1, 8'h50, 32'hAE);
    wait_idle();
    repeat (50) @(posedge clock_in);
    check_val("pulse width", 32'd12, 32'(last_width));
    check_val("pulse count", 32'd1, 32'(pulse_count));
    apb(1'b0, 8'h50, 32'h0);
    check_val("force bit kept", 32'hAE, rd);
    apb(1'b1, 8'h54, 32'h00);
    apb(1'b1, 8'h50, 32'h2E);
    apb(1'b1, 8'h50, 32'hAE);
    wait_idle();
    check_val("short pulse", 32'd2, 32'(last_width));
    apb(1'b1, 8'h50, 32'h20);
    foreach (fr[i]) begin
      apb(1'b1, 8'h5C, {24'h0, fr[i][31:24]});
      send_frame(8'hFF);
      check_val("first gap", 32'(fr[i][23:16] * ETU), 32'(first_w));
      check_val("last gap", 32'(fr[i][15:8] * ETU), 32'(last_width));
      check_val("gap count", {24'h0, fr[i][7:0]}, 32'(pulse_count - base));
    end
    // one-of-four frame: sof pulse, four symbol pulses, eof pulse
    apb(1'b1, 8'h50, 32'h2F);
    send_frame(8'hFF);
    check_val("sof pulse", 32'd232, 32'(first_w));
    check_val("eof pulse", 32'd2, 32'(last_width));
    check_val("pulse gaps", 32'd6, 32'(pulse_count - base));
    conclude();
  end
endmodule
`default_nettype wire
